/* File: shared/blmi_pkg.sv */
// shared constants, types and helpers for the byte lane mask/inversion block
package blmi_pkg;

  // lane geometry
  localparam int BLMI_LANES = 2;
  localparam int BLMI_LANE_W = 8;
  localparam int BLMI_DQ_W = BLMI_LANES * BLMI_LANE_W;

  // mode register field positions
  localparam int BLMI_MODE3_WR_INV_BIT = 7;
  localparam int BLMI_MODE3_RD_INV_BIT = 6;
  localparam int BLMI_MODE13_MASK_OFF_BIT = 5;

  // ones-count thresholds
  localparam logic [3:0] BLMI_INV_ONES_ABOVE = 4'h4;
  localparam logic [3:0] BLMI_MASK_ONES_MIN = 4'h5;
  localparam int BLMI_MASK_FIELD_LO = 2;

  // burst and buffering defaults
  localparam int BLMI_BEATS = 16;
  localparam int BLMI_FIFO_DEPTH = 4;

  // link timing: bench link period and system clock period
  localparam int BLMI_SYS_CLK_NS = 100;
  localparam int BLMI_LINK_PERIOD_NS = 800;
  localparam int BLMI_LINK_HALF_CYC = (BLMI_LINK_PERIOD_NS / 2) / BLMI_SYS_CLK_NS;

  // commands as decoded by the device command front end
  typedef enum logic [2:0] {
    BLMI_CMD_WRITE,
    BLMI_CMD_MASKED_WRITE,
    BLMI_CMD_READ,
    BLMI_CMD_MODE_REG_READBACK,
    BLMI_CMD_TRAIN_WR_FIFO,
    BLMI_CMD_TRAIN_RD_FIFO,
    BLMI_CMD_TRAIN_RD_CAL
  } blmi_cmd_t;

  // enables captured at burst start
  typedef struct packed {
    logic wr_inv;
    logic rd_inv;
    logic mask_en;
  } blmi_cfg_t;

  // link-side pin sample
  typedef struct packed {
    logic ck;
    logic [BLMI_LANES-1:0] pin;
    logic [BLMI_DQ_W-1:0] dq;
  } blmi_link_t;

  // one decoded write beat towards the array
  typedef struct packed {
    logic train;
    logic [BLMI_LANES-1:0] keep;
    logic [BLMI_DQ_W-1:0] data;
  } blmi_wr_beat_t;

  localparam int BLMI_WR_BEAT_W = $bits(blmi_wr_beat_t);

  // number of ones in a byte
  function automatic logic [3:0] blmi_ones(input logic [7:0] b);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, b[i]};
    end
    return n;
  endfunction

endpackage

/* File: core/blmi_fifo.sv */
// small valid/ready fifo for decoded write beats
`timescale 1ns/100ps
module blmi_fifo
  import blmi_pkg::*;
#(
  parameter int WIDTH = BLMI_WR_BEAT_W,
  parameter int DEPTH = BLMI_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("blmi_fifo depth must be a power of two of at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } blmi_fifo_state_t;

  blmi_fifo_state_t st;
  blmi_fifo_state_t next_st;
  logic push;
  logic pop;

  // honest flags straight from the occupancy count
  assign in_ready = (st.count != DEPTH[AW:0]);
  assign out_valid = (st.count != '0);
  assign out_data = st.mem[st.rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer and count update
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr_ptr] = in_data;
      next_st.wr_ptr = st.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_st.rd_ptr = st.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_st.count = st.count + 1'b1;
    end else if (pop && !push) begin
      next_st.count = st.count - 1'b1;
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

/* File: core/blmi_lane.sv */
// byte lane write masking and bus inversion datapath of one channel
`timescale 1ns/100ps
module blmi_lane
  import blmi_pkg::*;
#(
  parameter int BEATS = BLMI_BEATS,
  parameter int FIFO_DEPTH = BLMI_FIFO_DEPTH,
  parameter bit READBACK_INV = 1'b1,
  parameter logic [BLMI_BEATS-1:0] RD_CAL_PATTERN = 16'h5a5a
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] mode_reg_three,
  input wire logic [7:0] mode_reg_thirteen,
  input wire logic cmd_valid,
  input wire blmi_cmd_t cmd_kind,
  output logic cmd_ready,
  input wire logic link_ck,
  input wire logic [BLMI_DQ_W-1:0] dq_in,
  output logic [BLMI_DQ_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic [BLMI_LANES-1:0] mask_invert_pin_in,
  output logic [BLMI_LANES-1:0] mask_invert_pin_out,
  output logic [BLMI_LANES-1:0] mask_invert_pin_oe,
  output logic pin_rx_en,
  input wire logic rd_data_valid,
  output logic rd_data_ready,
  input wire logic [BLMI_DQ_W-1:0] rd_data,
  output logic array_wr_valid,
  input wire logic array_wr_ready,
  output blmi_wr_beat_t array_wr_beat,
  output logic burst_busy,
  output logic illegal_cmd,
  output logic write_overrun,
  output logic read_underrun
);

  localparam int BW = $clog2(BEATS + 1);

  generate
    if (BEATS < 2 || BEATS > BLMI_BEATS || (BEATS % 2) != 0) begin : g_bad_beats
      $error("blmi_lane burst length must be even and within the training store");
    end
  endgenerate

  typedef enum logic [1:0] {
    BLMI_IDLE,
    BLMI_WR_BURST,
    BLMI_RD_BURST
  } blmi_state_t;

  typedef struct packed {
    blmi_link_t s1;
    blmi_link_t s2;
    blmi_link_t s3;
    logic ck_level;
    blmi_state_t fsm;
    blmi_cmd_t kind;
    blmi_cfg_t cfg;
    logic [BW-1:0] beat;
    logic [BLMI_BEATS-1:0][BLMI_LANES-1:0] train;
    logic push_valid;
    blmi_wr_beat_t push_beat;
    logic [BLMI_DQ_W-1:0] dq_out;
    logic dq_oe;
    logic [BLMI_LANES-1:0] pin_out;
    logic [BLMI_LANES-1:0] pin_oe;
    logic rx_en;
    logic illegal;
    logic overrun;
    logic underrun;
  } blmi_lane_state_t;

  blmi_lane_state_t st;
  blmi_lane_state_t next_st;
  logic rst_meta;
  logic rst_n;
  logic fill_ready;
  logic beat_edge;
  blmi_cfg_t cmd_cfg;
  blmi_wr_beat_t wr_dec;
  logic [BLMI_DQ_W-1:0] rd_enc;
  logic [BLMI_LANES-1:0] rd_flag;

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // enables sampled from the mode bits only when a command is taken
  assign cmd_cfg.wr_inv = mode_reg_three[BLMI_MODE3_WR_INV_BIT];
  assign cmd_cfg.rd_inv = mode_reg_three[BLMI_MODE3_RD_INV_BIT];
  assign cmd_cfg.mask_en = !mode_reg_thirteen[BLMI_MODE13_MASK_OFF_BIT];

  // a link edge counts once stages two and three agree on a new level
  assign beat_edge = (st.s2.ck == st.s3.ck) && (st.s3.ck != st.ck_level);

  // per-lane decode of the incoming beat and encode of the outgoing beat
  generate
    for (genvar l = 0; l < BLMI_LANES; l++) begin : g_lane
      logic [7:0] rx;
      logic rx_pin;
      logic [7:0] tx;
      logic tx_heavy;
      logic upper_heavy;
      logic drop;
      logic flip;
      assign rx = st.s3.dq[l*BLMI_LANE_W +: BLMI_LANE_W];
      assign rx_pin = st.s3.pin[l];
      assign tx = rd_data[l*BLMI_LANE_W +: BLMI_LANE_W];
      assign tx_heavy = (blmi_ones(tx) > BLMI_INV_ONES_ABOVE);
      // only bits 2..7 are counted, so a mask code never looks like inverted data
      assign upper_heavy = (blmi_ones({rx[7:BLMI_MASK_FIELD_LO], 2'b00}) >= BLMI_MASK_ONES_MIN);

      // write-side lane decision by command and captured enables
      always_comb begin
        drop = 1'b0;
        flip = 1'b0;
        case (st.kind)
          BLMI_CMD_WRITE: begin
            flip = st.cfg.wr_inv && rx_pin;
          end
          BLMI_CMD_MASKED_WRITE: begin
            if (st.cfg.wr_inv) begin
              drop = !rx_pin && upper_heavy;
              flip = rx_pin;
            end else begin
              drop = rx_pin;
            end
          end
          default: begin
            drop = 1'b0;
            flip = 1'b0;
          end
        endcase
      end

      assign wr_dec.data[l*BLMI_LANE_W +: BLMI_LANE_W] = flip ? ~rx : rx;
      assign wr_dec.keep[l] = !drop;

      // read-side lane encode: readback may leave the pin low by build choice
      always_comb begin
        rd_flag[l] = 1'b0;
        case (st.kind)
          BLMI_CMD_READ: begin
            rd_flag[l] = st.cfg.rd_inv && tx_heavy;
          end
          BLMI_CMD_MODE_REG_READBACK: begin
            rd_flag[l] = st.cfg.rd_inv && READBACK_INV && tx_heavy;
          end
          default: begin
            rd_flag[l] = 1'b0;
          end
        endcase
      end

      assign rd_enc[l*BLMI_LANE_W +: BLMI_LANE_W] = rd_flag[l] ? ~tx : tx;
    end
  endgenerate

  assign wr_dec.train = (st.kind == BLMI_CMD_TRAIN_WR_FIFO);

  // handshakes towards the command front end and the read data source
  assign cmd_ready = (st.fsm == BLMI_IDLE);
  assign rd_data_ready = (st.fsm == BLMI_RD_BURST) && beat_edge && (st.beat < BEATS[BW-1:0]);

  // whole block state: synchroniser, burst sequencer and pin drivers
  always_comb begin
    next_st = st;
    next_st.s1 = '{ck: link_ck, pin: mask_invert_pin_in, dq: dq_in};
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2.ck == st.s3.ck) begin
      next_st.ck_level = st.s3.ck;
    end
    next_st.push_valid = 1'b0;
    next_st.illegal = 1'b0;
    next_st.overrun = 1'b0;
    next_st.underrun = 1'b0;
    case (st.fsm)
      BLMI_IDLE: begin
        if (cmd_valid) begin
          next_st.cfg = cmd_cfg;
          next_st.ck_level = st.s2.ck; // stages refilled after reset fake no beat
          next_st.kind = cmd_kind;
          next_st.beat = '0;
          if (cmd_kind == BLMI_CMD_MASKED_WRITE && !cmd_cfg.mask_en) begin
            next_st.illegal = 1'b1;
          end else if (cmd_kind == BLMI_CMD_WRITE) begin
            next_st.fsm = BLMI_WR_BURST;
            next_st.rx_en = cmd_cfg.wr_inv;
          end else if (cmd_kind == BLMI_CMD_MASKED_WRITE) begin
            next_st.fsm = BLMI_WR_BURST;
            next_st.rx_en = 1'b1;
          end else if (cmd_kind == BLMI_CMD_TRAIN_WR_FIFO) begin
            next_st.fsm = BLMI_WR_BURST;
            next_st.rx_en = cmd_cfg.wr_inv || cmd_cfg.mask_en;
          end else begin
            next_st.fsm = BLMI_RD_BURST;
            next_st.dq_oe = 1'b1;
            if (cmd_kind == BLMI_CMD_READ || cmd_kind == BLMI_CMD_MODE_REG_READBACK) begin
              next_st.pin_oe = {BLMI_LANES{cmd_cfg.rd_inv}};
            end else begin
              next_st.pin_oe = {BLMI_LANES{cmd_cfg.wr_inv || cmd_cfg.mask_en}};
            end
          end
        end
      end
      BLMI_WR_BURST: begin
        if (beat_edge) begin
          if (st.kind == BLMI_CMD_TRAIN_WR_FIFO) begin
            next_st.train[st.beat[BW-2:0]] = st.rx_en ? st.s3.pin : '0;
          end
          // the strobe cannot wait, so a full buffer loses the beat and says so
          if (fill_ready) begin
            next_st.push_valid = 1'b1;
            next_st.push_beat = wr_dec;
          end else begin
            next_st.overrun = 1'b1;
          end
          next_st.beat = st.beat + 1'b1;
          if (st.beat == BW'(BEATS - 1)) begin
            next_st.fsm = BLMI_IDLE;
            next_st.rx_en = 1'b0;
          end
        end
      end
      BLMI_RD_BURST: begin
        if (beat_edge) begin
          if (st.beat == BEATS[BW-1:0]) begin
            // drivers released one half period after the last beat
            next_st.fsm = BLMI_IDLE;
            next_st.dq_oe = 1'b0;
            next_st.pin_oe = '0;
            next_st.pin_out = '0;
            next_st.dq_out = '0;
          end else begin
            next_st.beat = st.beat + 1'b1;
            if (!rd_data_valid) begin
              next_st.underrun = 1'b1;
              next_st.dq_out = '0;
              next_st.pin_out = '0;
            end else begin
              next_st.dq_out = rd_enc;
              case (st.kind)
                BLMI_CMD_TRAIN_RD_FIFO: begin
                  next_st.pin_out = st.train[st.beat[BW-2:0]];
                end
                BLMI_CMD_TRAIN_RD_CAL: begin
                  next_st.pin_out = {BLMI_LANES{RD_CAL_PATTERN[st.beat[BW-2:0]]}};
                end
                default: begin
                  next_st.pin_out = rd_flag;
                end
              endcase
              next_st.pin_out = next_st.pin_out & st.pin_oe;
            end
          end
        end
      end
      default: begin
        next_st.fsm = BLMI_IDLE;
      end
    endcase
  end

  // state register on the released reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // decoded beats queue up for the array
  blmi_fifo #(
    .WIDTH(BLMI_WR_BEAT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(st.push_valid),
    .in_ready(fill_ready),
    .in_data(st.push_beat),
    .out_valid(array_wr_valid),
    .out_ready(array_wr_ready),
    .out_data(array_wr_beat)
  );

  // outputs straight from state
  assign dq_out = st.dq_out;
  assign dq_oe = st.dq_oe;
  assign mask_invert_pin_out = st.pin_out;
  assign mask_invert_pin_oe = st.pin_oe;
  assign pin_rx_en = st.rx_en;
  assign burst_busy = (st.fsm != BLMI_IDLE);
  assign illegal_cmd = st.illegal;
  assign write_overrun = st.overrun;
  assign read_underrun = st.underrun;

endmodule

/* File: test/blmi_lane_sva.sv */
// assertion checker for the byte lane mask/inversion block
`timescale 1ns/100ps
module blmi_lane_sva
  import blmi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] mode_reg_three,
  input wire logic [7:0] mode_reg_thirteen,
  input wire logic cmd_valid,
  input wire blmi_cmd_t cmd_kind,
  input wire logic cmd_ready,
  input wire logic [BLMI_DQ_W-1:0] dq_out,
  input wire logic dq_oe,
  input wire logic [BLMI_LANES-1:0] mask_invert_pin_out,
  input wire logic [BLMI_LANES-1:0] mask_invert_pin_oe,
  input wire logic pin_rx_en,
  input wire logic array_wr_valid,
  input wire logic array_wr_ready,
  input wire blmi_wr_beat_t array_wr_beat,
  input wire logic burst_busy,
  input wire logic write_overrun
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic rd_chk;
  // latch plain read with inversion at take, mode bits may move later
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rd_chk <= 1'b0;
    end else if (cmd_valid && cmd_ready) begin
      rd_chk <= cmd_kind == BLMI_CMD_READ && mode_reg_three[BLMI_MODE3_RD_INV_BIT];
    end else if (!burst_busy) begin
      rd_chk <= 1'b0;
    end
  end
  sequence s_take;
    cmd_valid && cmd_ready;
  endsequence
  sequence s_refused;
    s_take ##0 (cmd_kind == BLMI_CMD_MASKED_WRITE && mode_reg_thirteen[5]);
  endsequence
  AST_REFUSE: assert property (s_refused |=> !burst_busy ##1 cmd_ready)
    else $error("masked write with masking off started a burst");
  AST_TAKE: assert property (s_take ##0 (cmd_kind != BLMI_CMD_MASKED_WRITE) |=>
    burst_busy && !cmd_ready) else $error("taken command did not start a burst");
  AST_WR_RX: assert property (s_take ##0 (cmd_kind == BLMI_CMD_WRITE) |=>
    pin_rx_en == $past(mode_reg_three[7])) else $error("write receivers wrong");
  AST_RD_OE: assert property (s_take ##0 (cmd_kind == BLMI_CMD_READ) |=>
    dq_oe && mask_invert_pin_oe == {2{$past(mode_reg_three[6])}})
    else $error("read pin drivers wrong");
  AST_RD_INV: assert property (rd_chk && dq_oe |->
    $countones(dq_out[7:0]) <= (mask_invert_pin_out[0] ? 3 : 4) &&
    $countones(dq_out[15:8]) <= (mask_invert_pin_out[1] ? 3 : 4))
    else $error("read lane not inverted by ones count");
  AST_DIR: assert property (pin_rx_en |-> !dq_oe && mask_invert_pin_oe == 2'b00)
    else $error("pin received and driven together");
  AST_TRAIN: assert property (array_wr_valid && array_wr_beat.train |->
    array_wr_beat.keep == 2'b11) else $error("training beat masked");
  AST_HOLD: assert property (array_wr_valid && !array_wr_ready |=>
    array_wr_valid && $stable(array_wr_beat)) else $error("fifo output moved while stalled");
  AST_OVR: assert property (write_overrun |-> array_wr_valid)
    else $error("overrun with fifo not full");
  AST_RX_END: assert property ($fell(pin_rx_en) |-> !burst_busy)
    else $error("receivers changed inside a burst");
endmodule
bind blmi_lane blmi_lane_sva u_sva (.sys_clk, .rstn, .mode_reg_three, .mode_reg_thirteen,
  .cmd_valid, .cmd_kind, .cmd_ready, .dq_out, .dq_oe, .mask_invert_pin_out,
  .mask_invert_pin_oe, .pin_rx_en, .array_wr_valid, .array_wr_ready, .array_wr_beat,
  .burst_busy, .write_overrun);

/* File: test/blmi_ctrl_model.sv */
// memory controller model: link strobe, write data and mask/invert pin
`timescale 1ns/100ps
module blmi_ctrl_model
  import blmi_pkg::*;
(
  output logic link_ck,
  output logic [BLMI_DQ_W-1:0] dq,
  output logic [BLMI_LANES-1:0] pin
);
  initial begin
    link_ck = 1'b0;
    dq = 16'h0000;
    pin = 2'b00;
  end
  // one burst of n strobe edges, data changing with each edge
  task automatic run(input int n, input logic lo);
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      b = 8'(8'h11 * i);
      dq = {~b, b};
      pin = lo ? 2'b00 : 2'(i);
      link_ck = ~link_ck;
      #(BLMI_LINK_PERIOD_NS / 2);
    end
    // lines released: strobe stands still, data shows a moved pattern
    dq = ~dq;
    pin = ~pin;
  endtask
endmodule

/* File: test/tb_top.sv */
// self-checking bench for the byte lane mask/inversion block
`timescale 1ns/100ps
module tb_top;
  import blmi_pkg::*;
  typedef struct packed {
    blmi_cmd_t cmd;
    logic [7:0] mode3;
    logic [7:0] mode13;
    logic bad;
  } blmi_row_t;
  localparam logic [15:0] CAL = 16'h36c9;
  logic sys_clk, rstn, cmd_valid, cmd_ready, link_ck, dq_oe, pin_rx_en, rd_data_valid;
  logic rd_data_ready, array_wr_valid, array_wr_ready, burst_busy, illegal_cmd, pop_d;
  logic write_overrun, read_underrun;
  logic [7:0] mode_reg_three, mode_reg_thirteen;
  logic [15:0] dq_in, dq_out, rd_data, ctl_dq;
  logic [1:0] mask_invert_pin_in, mask_invert_pin_out, mask_invert_pin_oe, ctl_pin;
  blmi_cmd_t cmd_kind;
  blmi_wr_beat_t array_wr_beat;
  blmi_wr_beat_t wq[$];
  logic [17:0] rq[$];
  int miscompares, comparisons, ri, n_ill, n_ovr, n_und;
  blmi_row_t rows[13] = '{'{BLMI_CMD_WRITE, 8'h80, 8'h20, 0}, '{BLMI_CMD_WRITE, 8'h00, 8'h20, 0},
    '{BLMI_CMD_WRITE, 8'h00, 8'h00, 0}, '{BLMI_CMD_MASKED_WRITE, 8'h00, 8'h00, 0},
    '{BLMI_CMD_MASKED_WRITE, 8'h80, 8'h00, 0}, '{BLMI_CMD_MASKED_WRITE, 8'h80, 8'h20, 1},
    '{BLMI_CMD_READ, 8'h40, 8'h20, 0}, '{BLMI_CMD_READ, 8'h80, 8'h00, 0},
    '{BLMI_CMD_MODE_REG_READBACK, 8'h40, 8'h20, 0}, '{BLMI_CMD_TRAIN_WR_FIFO, 8'h80, 8'h20, 0},
    '{BLMI_CMD_TRAIN_RD_FIFO, 8'h80, 8'h20, 0}, '{BLMI_CMD_TRAIN_RD_CAL, 8'h00, 8'h00, 0},
    '{BLMI_CMD_TRAIN_RD_CAL, 8'h00, 8'h20, 0}};

  blmi_lane #(.RD_CAL_PATTERN(CAL)) dut (.sys_clk, .rstn, .mode_reg_three, .mode_reg_thirteen,
    .cmd_valid, .cmd_kind, .cmd_ready, .link_ck, .dq_in, .dq_out, .dq_oe, .mask_invert_pin_in,
    .mask_invert_pin_out, .mask_invert_pin_oe, .pin_rx_en, .rd_data_valid, .rd_data_ready,
    .rd_data, .array_wr_valid, .array_wr_ready, .array_wr_beat, .burst_busy, .illegal_cmd,
    .write_overrun, .read_underrun);
  blmi_ctrl_model ctl (.link_ck, .dq(ctl_dq), .pin(ctl_pin));
  // shared lines: the enabled party sets the level
  assign dq_in = dq_oe ? dq_out : ctl_dq;
  assign mask_invert_pin_in = (mask_invert_pin_oe & mask_invert_pin_out) |
    (~mask_invert_pin_oe & ctl_pin);

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // capture outputs before this edge's updates land
  always @(posedge sys_clk) begin
    if (array_wr_valid && array_wr_ready) begin
      wq.push_back(array_wr_beat);
    end
    if (pop_d) begin
      rq.push_back({mask_invert_pin_out, dq_out});
    end
    ri += rd_data_ready;
    n_ill += illegal_cmd;
    n_ovr += write_overrun;
    n_und += read_underrun;
    pop_d <= rd_data_ready;
  end
  // read source moves off the sampling edge
  always @(negedge sys_clk) begin
    rd_data <= pat(ri);
  end

  function automatic logic [15:0] pat(int i);
    logic [7:0] b;
    b = 8'(8'h11 * i);
    return {~b, b};
  endfunction
  function automatic logic [18:0] exwr(blmi_cmd_t c, logic wi, int i);
    logic [15:0] d;
    logic [1:0] p, k;
    d = pat(i);
    p = 2'(i);
    k = 2'b11;
    for (int l = 0; l < 2; l++) begin
      if (c == BLMI_CMD_MASKED_WRITE) begin
        k[l] = wi ? p[l] || $countones(d[8*l+2 +: 6]) < 5 : !p[l];
      end
      if (wi && p[l] && c != BLMI_CMD_TRAIN_WR_FIFO) begin
        d[8*l +: 8] = ~d[8*l +: 8];
      end
      if (!k[l]) begin
        d[8*l +: 8] = 8'h00;
      end
    end
    return {c == BLMI_CMD_TRAIN_WR_FIFO, k, d};
  endfunction
  function automatic logic [17:0] exrd(blmi_cmd_t c, logic rdi, logic wm, int i);
    logic [15:0] d;
    logic [1:0] p;
    logic iv;
    d = pat(i);
    p = 2'b00;
    iv = rdi && c inside {BLMI_CMD_READ, BLMI_CMD_MODE_REG_READBACK};
    for (int l = 0; l < 2; l++) begin
      if (iv && $countones(d[8*l +: 8]) > 4) begin
        p[l] = 1'b1;
        d[8*l +: 8] = ~d[8*l +: 8];
      end
    end
    if (c == BLMI_CMD_TRAIN_RD_FIFO && wm) begin
      p = 2'(i);
    end
    if (c == BLMI_CMD_TRAIN_RD_CAL && wm) begin
      p = {2{CAL[i]}};
    end
    return {p, d};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // bounded wait until the burst is over and the fifo hand-over is quiet
  task automatic wait_idle();
    for (int k = 0; k < 300; k++) begin
      @(negedge sys_clk);
      if (k > 1 && !burst_busy && !(array_wr_valid && array_wr_ready)) begin
        return;
      end
    end
    miscompares++;
    $display("MISMATCH %0t wait ran out", $time);
    stop_test();
  endtask
  task automatic run_row(blmi_row_t w);
    logic wi, wm, rd, rxe, oe;
    wi = w.mode3[7];
    wm = wi | !w.mode13[5];
    rd = w.cmd inside {BLMI_CMD_READ, BLMI_CMD_MODE_REG_READBACK, BLMI_CMD_TRAIN_RD_FIFO,
      BLMI_CMD_TRAIN_RD_CAL};
    rxe = w.cmd == BLMI_CMD_WRITE ? wi : w.cmd == BLMI_CMD_MASKED_WRITE ||
      (w.cmd == BLMI_CMD_TRAIN_WR_FIFO && wm);
    oe = w.cmd inside {BLMI_CMD_READ, BLMI_CMD_MODE_REG_READBACK} ? w.mode3[6] : rd && wm;
    wq.delete();
    rq.delete();
    ri = 0;
    n_ill = 0;
    n_ovr = 0;
    n_und = 0;
    mode_reg_three = w.mode3;
    mode_reg_thirteen = w.mode13;
    cmd_kind = w.cmd;
    cmd_valid = 1'b1;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    mode_reg_three = ~w.mode3;
    mode_reg_thirteen = ~w.mode13;
    check({pin_rx_en, mask_invert_pin_oe, dq_oe}, w.bad ? 0 : {rxe, {2{oe}}, rd});
    if (!w.bad) begin
      ctl.run(rd ? BLMI_BEATS + 1 : BLMI_BEATS, w.cmd == BLMI_CMD_WRITE && !wi && !w.mode13[5]);
    end
    wait_idle();
    check(n_ill, w.bad);
    if (!w.bad && rd) begin
      check(rq.size(), BLMI_BEATS);
      // a starved source gives zero data with the pin low on every beat
      foreach (rq[i]) begin
        check(rq[i], rd_data_valid ? exrd(w.cmd, w.mode3[6], wm, i) : 18'h0);
      end
    end
  endtask
  task automatic cmp_wr(int n, blmi_row_t w);
    check(wq.size(), n);
    foreach (wq[i]) check({wq[i].train, wq[i].keep, wq[i].data & {{8{wq[i].keep[1]}},
      {8{wq[i].keep[0]}}}}, exwr(w.cmd, w.mode3[7], i));
  endtask

  initial begin
    rstn = 1'b0;
    cmd_valid = 1'b0;
    cmd_kind = BLMI_CMD_WRITE;
    mode_reg_three = 8'h00;
    mode_reg_thirteen = 8'h20;
    rd_data_valid = 1'b1;
    array_wr_ready = 1'b1;
    rd_data = 16'h0000;
    pop_d = 1'b0;
    repeat (6) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (4) @(negedge sys_clk);
    foreach (rows[r]) begin
      run_row(rows[r]);
      if (!rows[r].bad && rows[r].cmd inside {BLMI_CMD_WRITE, BLMI_CMD_MASKED_WRITE,
          BLMI_CMD_TRAIN_WR_FIFO}) begin
        cmp_wr(BLMI_BEATS, rows[r]);
      end
    end
    // far side stalls: fifo fills to its depth, later beats are lost
    array_wr_ready = 1'b0;
    run_row(rows[0]);
    check(n_ovr, BLMI_BEATS - BLMI_FIFO_DEPTH);
    array_wr_ready = 1'b1;
    wait_idle();
    cmp_wr(BLMI_FIFO_DEPTH, rows[0]);
    // read source starved for a whole burst
    rd_data_valid = 1'b0;
    run_row(rows[6]);
    check(n_und, BLMI_BEATS);
    rd_data_valid = 1'b1;
    // reset in mid-burst drops straight to idle, then a burst still works
    cmd_kind = BLMI_CMD_WRITE;
    cmd_valid = 1'b1;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    fork
      ctl.run(BLMI_BEATS, 1'b0);
    join_none
    repeat (20) @(negedge sys_clk);
    rstn = 1'b0;
    #1;
    check({cmd_ready, burst_busy, array_wr_valid, pin_rx_en, dq_oe}, 5'b10000);
    wait fork;
    @(negedge sys_clk);
    rstn = 1'b1;
    repeat (4) @(negedge sys_clk);
    run_row(rows[4]);
    cmp_wr(BLMI_BEATS, rows[4]);
    stop_test();
  end
endmodule
